// ### src/spfc_cfg.svh
/*
 Constants of the flash self-programming controller: register offsets,
 field positions, control patterns, fuse selectors and timing counts.
 Assumes a 50 MHz pclk and byte addresses on an 8-bit APB paddr.
*/
`ifndef SPFC_CFG_SVH
`define SPFC_CFG_SVH

`define SPFC_OFF_CTRL     8'h00
`define SPFC_OFF_PTR      8'h04
`define SPFC_OFF_DATA     8'h08
`define SPFC_OFF_CMD      8'h0C
`define SPFC_OFF_RESULT   8'h10
`define SPFC_OFF_STATUS   8'h14

`define SPFC_BIT_EN       0
`define SPFC_BIT_RWW      6
`define SPFC_CMD_SPM      0
`define SPFC_CMD_LPM      1
`define SPFC_ST_HALT      0
`define SPFC_ST_EE        1

`define SPFC_PAT_NONE     5'h00
`define SPFC_PAT_LOAD     5'h01
`define SPFC_PAT_ERASE    5'h03
`define SPFC_PAT_WRITE    5'h05
`define SPFC_PAT_FUSE     5'h09
`define SPFC_PAT_CLEAR    5'h11

`define SPFC_SPM_WIN      3'h4
`define SPFC_LPM_WIN      3'h3

`define SPFC_SEL_LOW      16'h0000
`define SPFC_SEL_LOCK     16'h0001
`define SPFC_SEL_EXT      16'h0002
`define SPFC_SEL_HIGH     16'h0003
`define SPFC_NO_FUSE      8'hFF
`define SPFC_FUSE_RST     8'hFF

`define SPFC_PTR_RST      16'h0000
`define SPFC_WORD_BITS    5
`define SPFC_PAGE_BITS    (16 - 1 - `SPFC_WORD_BITS)

`define SPFC_CLK_NS       20
`define SPFC_PROG_MIN_NS  3700000
`define SPFC_PROG_MAX_NS  4500000
`define SPFC_PROG_CYC     ((`SPFC_PROG_MIN_NS + `SPFC_CLK_NS - 1) / `SPFC_CLK_NS)
`define SPFC_PROG_MAX_CYC (`SPFC_PROG_MAX_NS / `SPFC_CLK_NS)
`define SPFC_TMR_BITS     18

`endif

// ### src/spfc_pkg.sv
/*
 Types of the flash self-programming controller.
 Assumes spfc_cfg.svh is on the include path.
*/
package spfc_pkg;
`include "spfc_cfg.svh"

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_BUSY  = 3'b100
   } spfc_state_e;

   typedef struct packed {
      logic [`SPFC_PAGE_BITS-1:0] page;
      logic [`SPFC_WORD_BITS-1:0] word;
      logic [15:0]                data;
      logic                       erase;
      logic                       write;
      logic                       load;
      logic                       clear;
   } spfc_flash_cmd_s;

endpackage : spfc_pkg

// ### src/spfc_sync.sv
/*
 Two-flop synchroniser for slowly changing levels such as fuse pins.
 Assumes the input changes rarely, so words need no coherence guard.
*/
`timescale 1ns/1ns
module spfc_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_reg <= '1;
         q        <= '1;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : spfc_sync

// ### src/spfc_prog_timer.sv
/*
 Flash programming timer: counts a fixed number of clock cycles once started.
 Assumes its reset is the power-on reset only, so a system reset never
 cuts a running erase or write short.
*/
`timescale 1ns/1ns
`include "spfc_cfg.svh"
module spfc_prog_timer #(
   parameter int unsigned CYCLES = `SPFC_PROG_CYC
) (
   // Clock and power-on reset
   input  wire logic pclk,
   input  wire logic por_n,
   // Control
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   import spfc_pkg::*;

   localparam logic [`SPFC_TMR_BITS-1:0] LAST = `SPFC_TMR_BITS'(CYCLES - 1);

   logic [`SPFC_TMR_BITS-1:0] cnt_reg;
   logic [`SPFC_TMR_BITS-1:0] cnt_next;
   logic                      busy_next;
   logic                      done_next;

   always_comb
   begin
      cnt_next  = cnt_reg;
      busy_next = busy;
      done_next = 1'b0;
      if (busy)
      begin
         if (cnt_reg == LAST)
         begin
            busy_next = 1'b0;
            done_next = 1'b1;
            cnt_next  = '0;
         end
         else
         begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
      else if (start)
      begin
         busy_next = 1'b1;
         cnt_next  = '0;
      end
   end

   always_ff @(posedge pclk or negedge por_n)
   begin
      if (!por_n)
      begin
         cnt_reg <= '0;
         busy    <= 1'b0;
         done    <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         busy    <= busy_next;
         done    <= done_next;
      end
   end
endmodule : spfc_prog_timer

// ### src/spfc_ctrl.sv
/*
 Flash self-programming controller: APB slave holding the pointer, data,
 control registers and a write-only command register, arming windows, fuse/lock reads and the
 page erase/write sequencing with CPU halt.
 Assumes the CPU issues store/load program-memory operations as APB writes
 to the command register, and the flash array sits on flash_cmd.
*/
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "spfc_cfg.svh"
module spfc_ctrl
   import spfc_pkg::*;
#(
   parameter int unsigned PROG_CYCLES = `SPFC_PROG_CYC
) (
   // Clock and resets
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            por_n,
   // APB slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [7:0]      paddr,
   input  wire logic [31:0]     pwdata,
   output logic      [31:0]     prdata,
   output logic                 pready,
   output logic                 pslverr,
   // Device status
   input  wire logic            eeprom_write_busy_flag,
   input  wire logic [15:0]     flash_rword,
   // Fuse pins
   input  wire logic [7:0]      lock_byte_in,
   input  wire logic [7:0]      fuse_low_byte_in,
   input  wire logic [7:0]      fuse_high_byte_in,
   input  wire logic [7:0]      fuse_extended_byte_in,
   // Flash side
   output spfc_flash_cmd_s      flash_cmd,
   output logic      [15:0]     flash_byte_addr,
   output logic                 cpu_halt
);
   spfc_state_e     state_reg, state_next;
   spfc_flash_cmd_s cmd_next;
   logic [15:0]     ptr_reg, ptr_next;
   logic [15:0]     data_reg, data_next;
   logic [4:0]      mode_reg, mode_next;
   logic [2:0]      win_reg, win_next;
   logic [7:0]      result_reg, result_next;
   logic [31:0]     prdata_next;
   logic            pready_next, pslverr_next, halt_next;
   logic [31:0]     fuse_q;
   logic            access, wr, ctrl_wr, spm, lpm, blocked, start_go;
   logic            tmr_busy, tmr_done;

   function automatic logic pat_ok(input logic [4:0] p);
      return p == `SPFC_PAT_LOAD || p == `SPFC_PAT_ERASE || p == `SPFC_PAT_WRITE
          || p == `SPFC_PAT_FUSE || p == `SPFC_PAT_CLEAR;
   endfunction : pat_ok

   function automatic logic addr_ok(input logic [7:0] a);
      return a == `SPFC_OFF_CTRL || a == `SPFC_OFF_PTR || a == `SPFC_OFF_DATA
          || a == `SPFC_OFF_CMD || a == `SPFC_OFF_RESULT || a == `SPFC_OFF_STATUS;
   endfunction : addr_ok

   function automatic logic [7:0] fuse_pick(input logic [15:0] p, input logic [31:0] f);
      unique case (p)
         `SPFC_SEL_LOW:  return f[7:0];
         `SPFC_SEL_LOCK: return f[31:24];
         `SPFC_SEL_EXT:  return f[23:16];
         `SPFC_SEL_HIGH: return f[15:8];
         default:        return `SPFC_NO_FUSE;
      endcase
   endfunction : fuse_pick

   spfc_sync #(.W(32)) u_fuse_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({lock_byte_in, fuse_extended_byte_in, fuse_high_byte_in, fuse_low_byte_in}),
      .q       (fuse_q)
   );

   spfc_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
      .pclk  (pclk),
      .por_n (por_n),
      .start (start_go),
      .busy  (tmr_busy),
      .done  (tmr_done)
   );

   always_comb
   begin
      access  = psel && penable && pready;
      wr      = access && pwrite;
      ctrl_wr = wr && paddr == `SPFC_OFF_CTRL;
      spm     = wr && paddr == `SPFC_OFF_CMD && pwdata[`SPFC_CMD_SPM];
      lpm     = wr && paddr == `SPFC_OFF_CMD && pwdata[`SPFC_CMD_LPM];
      blocked = eeprom_write_busy_flag || tmr_busy;
   end

   always_comb
   begin
      state_next  = state_reg;
      mode_next   = mode_reg;
      win_next    = win_reg;
      result_next = result_reg;
      ptr_next    = ptr_reg;
      data_next   = data_reg;
      start_go    = 1'b0;
      cmd_next       = '0;
      cmd_next.page  = ptr_reg[15:`SPFC_WORD_BITS+1];
      cmd_next.word  = ptr_reg[`SPFC_WORD_BITS:1];
      cmd_next.data  = data_reg;
      if (wr && paddr == `SPFC_OFF_PTR)
         ptr_next = pwdata[15:0];
      if (wr && paddr == `SPFC_OFF_DATA)
         data_next = pwdata[15:0];
      if (lpm && !(state_reg == ST_ARMED && mode_reg == `SPFC_PAT_FUSE))
         result_next = ptr_reg[0] ? flash_rword[15:8] : flash_rword[7:0];
      unique case (state_reg)
         ST_IDLE:
         begin
            // accept only valid patterns when free
            if (ctrl_wr && pat_ok(pwdata[4:0]) && !blocked)
            begin
               mode_next  = pwdata[4:0];
               state_next = ST_ARMED;
               win_next   = pwdata[4:0] == `SPFC_PAT_FUSE ? `SPFC_LPM_WIN : `SPFC_SPM_WIN;
            end
         end
         ST_ARMED:
         begin
            win_next = win_reg - 3'h1;
            if (win_reg == 3'h0)
            begin
               state_next = ST_IDLE;
               mode_next  = `SPFC_PAT_NONE;
               win_next   = 3'h0;
            end
            else if (lpm && mode_reg == `SPFC_PAT_FUSE)
            begin
               result_next = fuse_pick(ptr_reg, fuse_q);
               state_next  = ST_IDLE;
               mode_next   = `SPFC_PAT_NONE;
               win_next    = 3'h0;
            end
            else if (spm && mode_reg != `SPFC_PAT_FUSE)
            begin
               win_next       = 3'h0;
               cmd_next.load  = mode_reg == `SPFC_PAT_LOAD;
               cmd_next.clear = mode_reg == `SPFC_PAT_CLEAR;
               cmd_next.erase = mode_reg == `SPFC_PAT_ERASE;
               cmd_next.write = mode_reg == `SPFC_PAT_WRITE;
               if (mode_reg == `SPFC_PAT_ERASE || mode_reg == `SPFC_PAT_WRITE)
               begin
                  start_go   = 1'b1;
                  state_next = ST_BUSY;
               end
               else
               begin
                  state_next = ST_IDLE;
                  mode_next  = `SPFC_PAT_NONE;
               end
            end
         end
         ST_BUSY:
         begin
            if (tmr_done)
            begin
               state_next = ST_IDLE;
               mode_next  = `SPFC_PAT_NONE;
            end
         end
      endcase
   end

   always_comb
   begin
      prdata_next  = '0;
      pready_next  = psel && !penable;
      pslverr_next = psel && !penable && !addr_ok(paddr);
      halt_next    = start_go || (tmr_busy && !tmr_done);
      if (psel && !penable && !pwrite)
      begin
         unique case (paddr)
            `SPFC_OFF_CTRL:
            begin
               prdata_next[`SPFC_BIT_RWW] = 1'b0;
               prdata_next[4:1]           = mode_reg[4:1];
               prdata_next[`SPFC_BIT_EN]  = state_reg != ST_IDLE || tmr_busy;
            end
            `SPFC_OFF_PTR:    prdata_next[15:0] = ptr_reg;
            `SPFC_OFF_DATA:   prdata_next[15:0] = data_reg;
            `SPFC_OFF_RESULT: prdata_next[7:0]  = result_reg;
            `SPFC_OFF_STATUS:
            begin
               prdata_next[`SPFC_ST_HALT] = cpu_halt;
               prdata_next[`SPFC_ST_EE]   = eeprom_write_busy_flag;
            end
            default:          prdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg       <= ST_IDLE;
         mode_reg        <= `SPFC_PAT_NONE;
         win_reg         <= 3'h0;
         ptr_reg         <= `SPFC_PTR_RST;
         data_reg        <= 16'h0000;
         result_reg      <= 8'h00;
         flash_cmd       <= '0;
         flash_byte_addr <= `SPFC_PTR_RST;
         cpu_halt        <= 1'b0;
         prdata          <= 32'h0000_0000;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
      end
      else
      begin
         state_reg       <= state_next;
         mode_reg        <= mode_next;
         win_reg         <= win_next;
         ptr_reg         <= ptr_next;
         data_reg        <= data_next;
         result_reg      <= result_next;
         flash_cmd       <= cmd_next;
         flash_byte_addr <= ptr_next;
         cpu_halt        <= halt_next;
         prdata          <= prdata_next;
         pready          <= pready_next;
         pslverr         <= pslverr_next;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   apb_zero_wait_a: assert property (psel && !penable |=> pready && psel)
      else $error("pready missing in access phase");
   spm_window_a: assert property (
      state_reg == ST_IDLE && ctrl_wr && !blocked && pwdata[4:0] == `SPFC_PAT_LOAD
      ##1 !spm [*5] |=> state_reg == ST_IDLE)
      else $error("store window not closed after four cycles");
   ee_block_a: assert property (
      state_reg == ST_IDLE && ctrl_wr && eeprom_write_busy_flag |=> state_reg == ST_IDLE)
      else $error("control write accepted during eeprom write");
   bad_pattern_a: assert property (
      state_reg == ST_IDLE && ctrl_wr && !pat_ok(pwdata[4:0]) |=> mode_reg == `SPFC_PAT_NONE)
      else $error("invalid control pattern took effect");
   lock_read_a: assert property (
      state_reg == ST_ARMED && mode_reg == `SPFC_PAT_FUSE && win_reg != 3'h0 && lpm
      && ptr_reg == `SPFC_SEL_LOCK |=> result_reg == fuse_q[31:24] && state_reg == ST_IDLE)
      else $error("lock byte not returned");
   fuse_low_a: assert property (
      state_reg == ST_ARMED && mode_reg == `SPFC_PAT_FUSE && win_reg != 3'h0 && lpm
      && ptr_reg == `SPFC_SEL_LOW |=> result_reg == fuse_q[7:0])
      else $error("fuse low byte not returned");
   fuse_window_a: assert property (
      $rose(state_reg == ST_ARMED) && mode_reg == `SPFC_PAT_FUSE ##1 !lpm [*4]
      |-> state_reg == ST_IDLE)
      else $error("fuse read arming not cleared");
   plain_load_a: assert property (
      state_reg == ST_IDLE && lpm |=> result_reg == ($past(ptr_reg[0]) ? $past(flash_rword[15:8])
      : $past(flash_rword[7:0])))
      else $error("plain load returned wrong byte");
   halt_hold_a: assert property (
      start_go |=> ##1 cpu_halt [*8] ##0 state_reg == ST_BUSY)
      else $error("halt or enable dropped during programming");
   rww_zero_a: assert property (
      psel && !penable && !pwrite && paddr == `SPFC_OFF_CTRL |=> !prdata[`SPFC_BIT_RWW])
      else $error("rww busy bit read as one");

   erase_c: cover property (start_go && mode_reg == `SPFC_PAT_ERASE);
   load_c: cover property (flash_cmd.load);
   fuse_c: cover property (state_reg == ST_ARMED && mode_reg == `SPFC_PAT_FUSE && lpm);
   expire_c: cover property (state_reg == ST_ARMED && win_reg == 3'h0);
endmodule : spfc_ctrl

// ### sim/spfc_flash_model.sv
/*
 Flash array model on the far side of the controller's flash command port.
 Assumes one-cycle command pulses and a same-clock word read at the pointer.
*/
`timescale 1ns/1ns
module spfc_flash_model
   import spfc_pkg::*;
(
   // Clock
   input  wire logic            pclk,
   // Command side
   input  wire spfc_flash_cmd_s flash_cmd,
   input  wire logic [15:0]     flash_byte_addr,
   // Read side
   output logic      [15:0]     flash_rword
);
   int         n_cmd = 0;
   logic [3:0] last_kind = 4'h0;
   logic [9:0] last_page = 10'h000;
   logic [4:0] last_word = 5'h00;
   logic [15:0] last_data = 16'h0000;

   // Array content is a fixed function of the word address, so any byte is predictable
   assign flash_rword = {flash_byte_addr[15:1], 1'b0} ^ 16'h5A3C;

   // Records every command pulse for the bench to inspect
   always @(posedge pclk)
   begin
      if (flash_cmd.erase | flash_cmd.write | flash_cmd.load | flash_cmd.clear)
      begin
         n_cmd     <= n_cmd + 1;
         last_kind <= {flash_cmd.erase, flash_cmd.write, flash_cmd.load, flash_cmd.clear};
         last_page <= flash_cmd.page;
         last_word <= flash_cmd.word;
         last_data <= flash_cmd.data;
      end
   end
endmodule : spfc_flash_model

// ### sim/self_program_flash_control_tb.sv
/*
 Self-checking bench of the flash self-programming controller over APB.
 Assumes spfc_cfg.svh on the include path and a shortened programming time.
*/
`timescale 1ns/1ns
`include "spfc_cfg.svh"
module self_program_flash_control_tb;
   import spfc_pkg::*;
   localparam int PROG = 20;
   logic            pclk = 1'b0;
   logic            presetn = 1'b0;
   logic            por_n = 1'b0;
   logic            psel = 1'b0;
   logic            penable = 1'b0;
   logic            pwrite = 1'b0;
   logic [7:0]      paddr = 8'h00;
   logic [31:0]     pwdata = 32'h0;
   logic [31:0]     prdata;
   logic            pready;
   logic            pslverr;
   logic            ee_busy = 1'b0;
   logic [15:0]     flash_rword;
   spfc_flash_cmd_s flash_cmd;
   logic [15:0]     flash_byte_addr;
   logic            cpu_halt;
   logic [7:0]      fuse_v [0:4] = '{8'h62, 8'hFC, 8'hFE, 8'hDF, 8'hFF};
   logic [4:0]      pats [0:3] = '{5'h01, 5'h03, 5'h05, 5'h11};
   logic [3:0]      kinds [0:3] = '{4'h2, 4'h8, 4'h4, 4'h1};
   logic [31:0]     rdat;
   logic            rerr;
   logic            halt_q = 1'b0;
   int              halt_run = 0;
   int              failures = 0;
   int              num_checks = 0;
   int              k0;

   always #10 pclk = ~pclk;

   spfc_ctrl #(.PROG_CYCLES(PROG)) dut (
      .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .eeprom_write_busy_flag(ee_busy), .flash_rword(flash_rword),
      .lock_byte_in(fuse_v[1]), .fuse_low_byte_in(fuse_v[0]), .fuse_high_byte_in(fuse_v[3]),
      .fuse_extended_byte_in(fuse_v[2]), .flash_cmd(flash_cmd),
      .flash_byte_addr(flash_byte_addr), .cpu_halt(cpu_halt));

   spfc_flash_model u_flash (.pclk(pclk), .flash_cmd(flash_cmd),
      .flash_byte_addr(flash_byte_addr), .flash_rword(flash_rword));

   // Length of the latest halt run, kept after it ends
   always @(posedge pclk)
   begin
      halt_q <= (cpu_halt === 1'b1);
      if (cpu_halt === 1'b1)
         halt_run <= halt_q ? halt_run + 1 : 1;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Request held until pready is sampled high, released only after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      rdat = prdata;
      rerr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50)
      begin
         failures++;
         conclude();
      end
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hFFFF_FFFF);
      apb(1'b0, a, 32'h0);
      check(rdat & m, exp);
   endtask : rd

   task automatic wait_halt_end;
      int n;
      n = 0;
      while (cpu_halt !== 1'b0 && n < 200)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 200)
      begin
         failures++;
         conclude();
      end
   endtask : wait_halt_end

   function automatic logic [31:0] fbyte(input logic [15:0] a);
      logic [15:0] w;
      w = {a[15:1], 1'b0} ^ 16'h5A3C;
      return {24'h0, a[0] ? w[15:8] : w[7:0]};
   endfunction : fbyte

   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      por_n   <= 1'b1;
      repeat (3) @(posedge pclk);
      rd(`SPFC_OFF_CTRL, 32'h0);
      rd(`SPFC_OFF_STATUS, 32'h0);
      rd(`SPFC_OFF_CMD, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      check({31'h0, rerr}, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 2; i++)
      begin
         wr(`SPFC_OFF_PTR, 32'h1234 + i);
         wr(`SPFC_OFF_CMD, 32'h2);
         rd(`SPFC_OFF_RESULT, fbyte(16'h1234 + i));
      end
      $display("test plain load done");
      for (int i = 0; i < 5; i++)
      begin
         wr(`SPFC_OFF_PTR, i);
         wr(`SPFC_OFF_CTRL, 32'h09);
         wr(`SPFC_OFF_CMD, 32'h2);
         rd(`SPFC_OFF_RESULT, {24'h0, fuse_v[i]});
         rd(`SPFC_OFF_CTRL, 32'h0);
      end
      wr(`SPFC_OFF_PTR, 32'h1);
      wr(`SPFC_OFF_CTRL, 32'h09);
      repeat (4) @(posedge pclk);
      wr(`SPFC_OFF_CMD, 32'h2);
      rd(`SPFC_OFF_RESULT, fbyte(16'h0001));
      $display("test fuse read done");
      // same page for erase and the following write
      for (int i = 0; i < 4; i++)
      begin
         k0 = u_flash.n_cmd;
         wr(`SPFC_OFF_PTR, 32'hABCF);
         wr(`SPFC_OFF_DATA, 32'h1230 + i);
         rd(`SPFC_OFF_CTRL, 32'h0, 32'h1);
         wr(`SPFC_OFF_CTRL, {27'h0, pats[i]});
         wr(`SPFC_OFF_CMD, 32'h1);
         if (i == 1 || i == 2)
         begin
            rd(`SPFC_OFF_CTRL, 32'h1, 32'h1);
            rd(`SPFC_OFF_STATUS, 32'h1, 32'h1);
            wait_halt_end();
            check(32'(halt_run >= PROG && halt_run <= PROG + 2), 32'h1);
            rd(`SPFC_OFF_CTRL, 32'h0, 32'h1);
         end
         repeat (3) @(posedge pclk);
         check(32'(u_flash.n_cmd - k0), 32'h1);
         check({28'h0, u_flash.last_kind}, {28'h0, kinds[i]});
         check({22'h0, u_flash.last_page}, 32'hABCF >> 6);
         check({27'h0, u_flash.last_word}, (32'hABCF >> 1) & 32'h1F);
         check({16'h0, u_flash.last_data}, 32'h1230 + i);
      end
      $display("test commands done");
      k0 = u_flash.n_cmd;
      wr(`SPFC_OFF_CTRL, 32'h01);
      repeat (5) @(posedge pclk);
      wr(`SPFC_OFF_CMD, 32'h1);
      wr(`SPFC_OFF_CTRL, 32'h07);
      rd(`SPFC_OFF_CTRL, 32'h0);
      wr(`SPFC_OFF_CMD, 32'h1);
      // busy raised on purpose to see the refusal
      ee_busy <= 1'b1;
      rd(`SPFC_OFF_STATUS, 32'h2);
      wr(`SPFC_OFF_CTRL, 32'h01);
      wr(`SPFC_OFF_CMD, 32'h1);
      wr(`SPFC_OFF_PTR, 32'h1);
      wr(`SPFC_OFF_CTRL, 32'h09);
      wr(`SPFC_OFF_CMD, 32'h2);
      rd(`SPFC_OFF_RESULT, fbyte(16'h0001));
      ee_busy <= 1'b0;
      repeat (3) @(posedge pclk);
      check(32'(u_flash.n_cmd - k0), 32'h0);
      $display("test refusals done");
      k0 = u_flash.n_cmd;
      wr(`SPFC_OFF_CTRL, 32'h03);
      wr(`SPFC_OFF_CMD, 32'h1);
      repeat (5) @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(`SPFC_OFF_CTRL, 32'h1, 32'h1);
      check({31'h0, cpu_halt}, 32'h1);
      wait_halt_end();
      rd(`SPFC_OFF_CTRL, 32'h0, 32'h1);
      check(32'(u_flash.n_cmd - k0), 32'h1);
      $display("test reset during erase done");
      conclude();
   end
endmodule : self_program_flash_control_tb
